//--- design/evpd_pkg.sv
// constants and types for the exception vector priority decoder
package evpd_pkg;
   localparam int          EVPD_NUM_MASK = 120;
   localparam logic [15:0] VEC_SYS_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_XTAL_MON  = 16'hFFFC;
   localparam logic [15:0] VEC_WATCHDOG  = 16'hFFFA;
   localparam logic [15:0] VEC_UNIMP_OP  = 16'hFFF8;
   localparam logic [15:0] VEC_SW_TRAP   = 16'hFFF6;
   localparam logic [15:0] VEC_NMI_PIN   = 16'hFFF4;
   localparam logic [15:0] VEC_IRQ_PIN   = 16'hFFF2;
   localparam logic [15:0] VEC_MASK_TOP  = 16'hFFF0;
   localparam logic [15:0] VEC_MASK_BASE = 16'hFF00;
   localparam logic [7:0]  PROMO_LIMIT   = 8'hF2;
   localparam logic [7:0]  VEC_STEP      = 8'h02;
   typedef struct packed {
      logic [15:0] vector;
      logic        vec_valid;
      logic [15:0] last_vec;
      logic        seen;
      logic        req_d;
   } evpd_state_t;
endpackage

//--- design/evpd_if.sv
// request bundle between the decoder top and its source scanner
`timescale 1ns/1ps
interface evpd_if #(parameter int NUM_MASK = 120);
   logic [NUM_MASK-1:0] mask_req;
   logic [7:0]          promo_sel;
   logic                hit;
   logic [15:0]         vec;
   modport scan (input mask_req, input promo_sel, output hit, output vec);
   modport top  (output mask_req, output promo_sel, input hit, input vec);
endinterface

//--- design/evpd_mask_scan.sv
// maskable source scanner with optional promotion
`timescale 1ns/1ps
module evpd_mask_scan
   import evpd_pkg::*;
(
   evpd_if.scan bus
);
   localparam int N = $bits(bus.mask_req);
   logic [N-1:0]  promo_hit_vec;
   logic          promo_ok;
   logic          promo_act;
   logic [15:0]   promo_vec;
   // source i owns vector 0xFFF0 - 2*i, so index 0 ranks highest
   genvar gi;
   for (gi = 0; gi < N; gi++) begin : g_promo
      localparam logic [7:0] LSB = 8'(VEC_MASK_TOP[7:0] - 8'(gi * VEC_STEP));
      assign promo_hit_vec[gi] = (bus.promo_sel == LSB) && bus.mask_req[gi];
   end
   always_comb begin
      promo_ok  = 1'b0;
      promo_act = 1'b0;
      promo_vec = VEC_IRQ_PIN;
      for (int i = 0; i < N; i++) begin
         if (bus.promo_sel == 8'(VEC_MASK_TOP[7:0] - 8'(i * VEC_STEP))) begin
            promo_ok = 1'b1;
         end
      end
      // no match keeps promo_ok low, so the irq pin stays on top
      if (promo_ok && (|promo_hit_vec)) begin
         promo_act = 1'b1;
         promo_vec = {VEC_MASK_TOP[15:8], bus.promo_sel};
      end
      bus.hit = promo_act;
      bus.vec = promo_vec;
      if (!promo_act) begin
         for (int i = N - 1; i >= 0; i--) begin
            if (bus.mask_req[i]) begin
               bus.hit = 1'b1;
               bus.vec = {VEC_MASK_TOP[15:8], 8'(VEC_MASK_TOP[7:0] - 8'(i * VEC_STEP))};
            end
         end
      end
   end
endmodule

//--- design/evpd_top.sv
// exception vector priority decoder top
`timescale 1ns/1ps
// What this block does
// - examine every pending request each cycle
// - vector request returns highest valid vector
// - winner chosen at request time only
// - vanished source returns last valid vector
// - nothing ever pending returns software trap vector
// - resets rank first: system, crystal, watchdog
// - then opcode trap, software/debug, nmi, irq
// - maskable sources lowest, higher address wins
// - promoted maskable source tops irq and other maskables
// - invalid promotion promotes the irq pin
module evpd_top
   import evpd_pkg::*;
#(
   parameter int NUM_MASK = evpd_pkg::EVPD_NUM_MASK
) (
   // clock and reset
   input  wire logic                sys_clk,
   input  wire logic                rst_n,
   // exception sources
   input  wire logic                sys_reset_req,
   input  wire logic                xtal_mon_req,
   input  wire logic                watchdog_reset_source,
   input  wire logic                unimp_opcode_req,
   input  wire logic                software_trap_instruction,
   input  wire logic                debug_mode_request,
   input  wire logic                nonmaskable_request_pin,
   input  wire logic                irq_pin_req,
   input  wire logic [NUM_MASK-1:0] mask_src_req,
   // promotion unit selection (low byte of vector)
   input  wire logic [7:0]          promotion_unit,
   // cpu vector handshake
   input  wire logic                vec_req,
   output logic [15:0]              vec_addr,
   output logic                     vec_valid
);
   import evpd_pkg::*;
   evpd_state_t st;
   evpd_state_t next_st;
   logic        pend;
   logic [15:0] win_vec;
   logic        promo_valid;
   logic        promo_live;
   logic        take;
   logic        fixed_hi;
   evpd_if #(.NUM_MASK(NUM_MASK)) sbus ();
   assign sbus.mask_req  = mask_src_req;
   assign sbus.promo_sel = promotion_unit;
   evpd_mask_scan u_scan (
      .bus (sbus)
   );
   // promotion valid only when it names an implemented maskable vector
   always_comb begin
      promo_valid = 1'b0;
      promo_live  = 1'b0;
      for (int i = 0; i < NUM_MASK; i++) begin
         if (promotion_unit == 8'(VEC_MASK_TOP[7:0] - 8'(i * VEC_STEP))) begin
            promo_valid = 1'b1;
            promo_live  = mask_src_req[i];
         end
      end
   end
   // request edge and fixed-source summary, kept apart from the scanner for the checks
   assign take     = vec_req && !st.req_d;
   assign fixed_hi = sys_reset_req || xtal_mon_req || watchdog_reset_source
                     || unimp_opcode_req || software_trap_instruction || debug_mode_request;
   // fixed priority chain, evaluated every cycle
   always_comb begin
      pend    = 1'b1;
      win_vec = VEC_SW_TRAP;
      if (sys_reset_req) begin
         win_vec = VEC_SYS_RESET;
      end else if (xtal_mon_req) begin
         win_vec = VEC_XTAL_MON;
      end else if (watchdog_reset_source) begin
         win_vec = VEC_WATCHDOG;
      end else if (unimp_opcode_req) begin
         win_vec = VEC_UNIMP_OP;
      end else if (software_trap_instruction || debug_mode_request) begin
         win_vec = VEC_SW_TRAP;
      end else if (nonmaskable_request_pin) begin
         win_vec = VEC_NMI_PIN;
      end else if (!promo_valid && irq_pin_req) begin
         win_vec = VEC_IRQ_PIN;
      end else if (promo_valid && sbus.hit && (sbus.vec[7:0] == promotion_unit)) begin
         win_vec = sbus.vec;
      end else if (irq_pin_req) begin
         win_vec = VEC_IRQ_PIN;
      end else if (sbus.hit) begin
         win_vec = sbus.vec;
      end else begin
         pend = 1'b0;
      end
   end
   always_comb begin
      next_st       = st;
      next_st.req_d = vec_req;
      if (pend) begin
         next_st.seen     = 1'b1;
         next_st.last_vec = win_vec;
      end
      // sample only on the request edge, then hold
      if (vec_req && !st.req_d) begin
         next_st.vec_valid = 1'b1;
         if (pend) begin
            next_st.vector = win_vec;
         end else if (st.seen) begin
            next_st.vector = st.last_vec;
         end else begin
            next_st.vector = VEC_SW_TRAP;
         end
      end else if (!vec_req) begin
         next_st.vec_valid = 1'b0;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= '{vector: VEC_SW_TRAP, vec_valid: 1'b0, last_vec: VEC_SW_TRAP,
                 seen: 1'b0, req_d: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign vec_addr  = st.vector;
   assign vec_valid = st.vec_valid;

   // resets rank first, each with its own vector
   a_sys_reset_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && sys_reset_req
      |=> vec_addr == VEC_SYS_RESET)
      else $error("system reset vector not returned");
   a_xtal_mon_second: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !sys_reset_req && xtal_mon_req
      |=> vec_addr == VEC_XTAL_MON)
      else $error("crystal monitor vector not returned");
   a_watchdog_third: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !sys_reset_req && !xtal_mon_req && watchdog_reset_source
      |=> vec_addr == VEC_WATCHDOG)
      else $error("watchdog vector not returned");
   // traps and the two request pins
   a_unimp_op_fourth: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !sys_reset_req && !xtal_mon_req && !watchdog_reset_source && unimp_opcode_req
      |=> vec_addr == VEC_UNIMP_OP)
      else $error("opcode trap vector not returned");
   a_trap_debug_shared: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !sys_reset_req && !xtal_mon_req && !watchdog_reset_source && !unimp_opcode_req
      && (software_trap_instruction || debug_mode_request)
      |=> vec_addr == VEC_SW_TRAP)
      else $error("shared trap vector not returned");
   a_nmi_over_irq: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && !st.req_d && nonmaskable_request_pin && !sys_reset_req && !xtal_mon_req
      && !watchdog_reset_source && !unimp_opcode_req && !software_trap_instruction
      && !debug_mode_request |=> vec_addr == VEC_NMI_PIN)
      else $error("nonmaskable vector not returned");
   a_irq_over_plain: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !fixed_hi && !nonmaskable_request_pin && irq_pin_req && !promo_live
      |=> vec_addr == VEC_IRQ_PIN)
      else $error("irq vector lost to a plain maskable");
   // maskable sources and promotion
   a_promoted_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !fixed_hi && !nonmaskable_request_pin && promo_live
      |=> vec_addr == {VEC_MASK_TOP[15:8], $past(promotion_unit)})
      else $error("promoted vector not returned");
   a_irq_unpromoted: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !fixed_hi && !nonmaskable_request_pin && irq_pin_req && !promo_valid
      && (|mask_src_req) |=> vec_addr == VEC_IRQ_PIN)
      else $error("invalid promotion did not favour irq");
   a_mask_top_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !fixed_hi && !nonmaskable_request_pin && !irq_pin_req && !promo_live
      && mask_src_req[0] |=> vec_addr == VEC_MASK_TOP)
      else $error("top maskable vector not returned");
   a_mask_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
      take && !fixed_hi && !nonmaskable_request_pin && !irq_pin_req && (|mask_src_req)
      |=> vec_addr <= VEC_MASK_TOP && vec_addr >= VEC_MASK_BASE)
      else $error("maskable vector out of range");
   a_mask_range_ok: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_valid
      |-> vec_addr >= VEC_MASK_BASE && !vec_addr[0])
      else $error("vector out of map");
   // fallbacks and history
   a_never_pending_swi: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && !st.req_d && !pend && !st.seen
      |=> vec_addr == VEC_SW_TRAP)
      else $error("default software trap vector missing");
   a_reset_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !$past(rst_n)
      |-> vec_addr == VEC_SW_TRAP && !vec_valid && !st.seen)
      else $error("history not cleared by reset");
   a_last_valid_used: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && !st.req_d && !pend && st.seen
      |=> vec_addr == $past(st.last_vec))
      else $error("last valid vector not returned");
   a_history_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pend
      |=> st.seen && st.last_vec == $past(win_vec))
      else $error("pending winner not remembered");
   a_history_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !pend
      |=> $stable(st.last_vec))
      else $error("history changed with nothing pending");
   // sampling and handshake
   a_sampled_winner: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && !st.req_d && pend
      |=> vec_addr == $past(win_vec))
      else $error("winner not returned at request");
   a_no_resample: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && st.req_d
      |=> $stable(vec_addr) && vec_valid)
      else $error("held request sampled again");
   a_vector_held_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_valid && vec_req
      |=> $stable(vec_addr))
      else $error("vector changed while request held");
   a_valid_follows_req: assert property (@(posedge sys_clk) disable iff (!rst_n)
      vec_req && !st.req_d
      |=> vec_valid ##1 (vec_valid || !$past(vec_req)))
      else $error("vector valid not raised");
   a_valid_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !vec_req
      |=> !vec_valid)
      else $error("vector valid outlived request");
   // every pending source is seen each cycle
   a_scan_sees_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (|mask_src_req)
      |-> sbus.hit)
      else $error("pending maskable not seen");
   a_pend_any: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fixed_hi || nonmaskable_request_pin || irq_pin_req || (|mask_src_req)
      |-> pend)
      else $error("pending request not flagged");
endmodule

//--- sim/evpd_cpu_model.sv
// cpu side model that asks for vectors
`timescale 1ns/1ps
module evpd_cpu_model (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // vector handshake
   input  wire logic vec_valid,
   output logic      vec_req
);
   integer seed = 17149;
   integer hold = 0;
   initial vec_req = 1'b0;
   // low for at least one cycle between requests, held until answered
   always @(posedge sys_clk) begin
      #1;
      if (!rst_n || (vec_req && vec_valid && hold == 0)) begin
         vec_req = 1'b0;
         hold = $unsigned($random(seed)) % 3;
      end else if (vec_req && vec_valid)
         hold--;
      else if (!vec_req)
         vec_req = 1'b1;
   end
endmodule

//--- sim/test_evpd_top.sv
// self-checking bench for the exception vector priority decoder
`timescale 1ns/1ps
module test_evpd_top;
   import evpd_pkg::*;
   logic         sys_clk = 1'b0;
   logic         rst_n   = 1'b0;
   logic [7:0]   src     = '0;
   logic [119:0] mask    = '0;
   logic [7:0]   promo   = '0;
   logic         vec_req;
   logic [15:0]  vec_addr;
   logic         vec_valid;
   logic [15:0]  exp_cur   = VEC_SW_TRAP;
   logic [15:0]  last      = VEC_SW_TRAP;
   logic [15:0]  w;
   logic         exp_valid = 1'b0;
   logic         req_d     = 1'b0;
   logic [31:0]  r;
   integer       seed = 17149;
   integer       num_errors = 0;
   integer       num_checks = 0;
   integer       cycles = 0;
   integer       k, i1, i2;
   always #2.5 sys_clk = ~sys_clk;
   evpd_top #(.NUM_MASK(120)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .sys_reset_req(src[0]), .xtal_mon_req(src[1]), .watchdog_reset_source(src[2]),
      .unimp_opcode_req(src[3]), .software_trap_instruction(src[4]),
      .debug_mode_request(src[5]), .nonmaskable_request_pin(src[6]), .irq_pin_req(src[7]),
      .mask_src_req(mask), .promotion_unit(promo), .vec_req(vec_req),
      .vec_addr(vec_addr), .vec_valid(vec_valid));
   evpd_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .vec_valid(vec_valid),
      .vec_req(vec_req));
   function automatic logic [15:0] win(logic [7:0] s, logic [119:0] m, logic [7:0] p);
      for (int i = 0; i < 7; i++)
         if (s[i]) return 16'hFFFE - 16'(2 * (i - (i > 4)));
      if (p <= 8'hF0 && p >= 8'h02 && !p[0] && m[(240 - p) / 2]) return {8'hFF, p};
      if (s[7]) return 16'hFFF2;
      for (int i = 0; i < 120; i++)
         if (m[i]) return 16'hFFF0 - 16'(2 * i);
      return '0;
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      num_checks++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic check_flag(input logic got, input logic want);
      num_checks++;
      if (got !== want) begin
         num_errors++;
         $display("wrong value at %0t: flag got %b want %b", $time, got, want);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // reference model on the falling edge: outputs are settled there, and the
   // inputs already hold what the next rising edge will sample
   always @(negedge sys_clk) begin
      cycles++;
      if (cycles > 3000) begin
         num_errors++;
         close_out;
      end else begin
         check(vec_addr, exp_cur);
         check_flag(vec_valid, exp_valid);
         if (!rst_n) begin
            {exp_cur, last, exp_valid, req_d} = {VEC_SW_TRAP, VEC_SW_TRAP, 2'b00};
         end else begin
            w = win(src, mask, promo);
            if (vec_req && !req_d) exp_cur = (w !== '0) ? w : last;
            if (w !== '0) last = w;
            exp_valid = vec_req;
            req_d = vec_req;
         end
      end
   end
   initial begin
      // second pass resets mid-run, so history must clear
      for (k = 0; k < 2; k++) begin
         {rst_n, src, mask} = '0;
         tick(4);
         rst_n = 1'b1;
         tick(12);
         for (int b = 0; b < 8; b++) begin
            src = ((8'hFF << b) & 8'($random(seed))) | (8'h01 << b);
            tick(10);
         end
         $display("test reset and fixed order done");
      end
      // sources come and go, some vanish before the vector request
      for (k = 0; k < 400; k++) begin
         r = $random(seed);
         i1 = $unsigned($random(seed)) % 120;
         i2 = $unsigned($random(seed)) % 120;
         src = (r[1:0] == 0) ? 8'($random(seed) & $random(seed) & $random(seed)) : '0;
         mask = r[2] ? ((120'(1) << i1) | (120'(r[4]) << i2)) : '0;
         promo = r[3] ? 8'hF0 - 8'(2 * i2) : 8'($random(seed));
         tick(1 + r[6:5]);
      end
      $display("test random mix done");
      close_out;
   end
endmodule
